/* hw/tbt_touch_baseline_tracker.sv */
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "tbt_consts.svh"
module tbt_touch_baseline_tracker #(
   parameter int NKEY = 16
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              scan_valid,
   input  wire tbt_pkg::tbt_scan_t scan_in,
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   touch_irq_n,
   output logic                   buzzer_sel,
   output logic                   melody_power_ctrl,
   output logic                   addr_sel,
   output logic                   sleep_active
);
   import tbt_pkg::*;

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            o[8*i +: 8] = d[8*i +: 8];
         end
      end
      merge = o;
   endfunction

   logic [15:0]    base_reg [NKEY];
   logic [15:0]    raw_reg  [NKEY];
   logic [7:0]     cnt_reg  [NKEY];
   logic [7:0]     nthr_reg [NKEY];
   logic [7:0]     lbr_reg  [NKEY];
   logic [7:0]     pthr_reg [NKEY];
   logic [7:0]     fthr_reg [NKEY];
   logic [NKEY-1:0] touch_reg;
   logic [15:0]    lock_reg;
   tbt_ctrl_t      ctrl_reg;
   logic [2:0]     icfg_reg, stat_reg, mask_reg, stat_next, ev;
   logic [3:0]     k, chk_key_q;
   logic [15:0]    cur_base, diff, sig, chk_raw_q;
   logic [7:0]     cur_cnt, cnt_inc;
   logic           pin_used, chan_ok, locked, eval, over, lbr_hit, upd_base, touched;

   // scan evaluation, lock check ahead of baseline and counter
   always_comb begin
      k        = scan_in.key;
      cur_base = base_reg[k];
      cur_cnt  = cnt_reg[k];
      diff     = absdiff(scan_in.raw, cur_base);
      sig      = (scan_in.raw > cur_base) ? scan_in.raw - cur_base : 16'h0000;
      pin_used = (k == 4'h0 && ctrl_reg.key0_buzz) || (k == 4'hC && ctrl_reg.key12_pow)
              || (k == 4'hF && ctrl_reg.key15_addr);
      chan_ok  = scan_valid && !pin_used;
      locked   = chan_ok && (sig > lock_reg);
      eval     = chan_ok && !locked;
      over     = diff > {8'h00, nthr_reg[k]};
      cnt_inc  = (cur_cnt == `TBT_CNT_MAX) ? cur_cnt : cur_cnt + 8'h01;
      lbr_hit  = over && (cnt_inc > lbr_reg[k]);
      upd_base = eval && ((diff < {8'h00, pthr_reg[k]}) || lbr_hit);
      touched  = sig >= {8'h00, fthr_reg[k]};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NKEY; i++) begin
            base_reg[i] <= 16'h0000;
            cnt_reg[i]  <= 8'h00;
            raw_reg[i]  <= 16'h0000;
         end
      end else if (chan_ok) begin
         raw_reg[k] <= scan_in.raw;
         if (upd_base) begin
            base_reg[k] <= scan_in.raw;
         end
         if (eval) begin
            // counter restarts once it has forced the baseline
            cnt_reg[k] <= (!over || lbr_hit) ? 8'h00 : cnt_inc;
         end
      end
   end

   // touch decisions pause while asleep; tracking keeps running
   // the waking touch is kept, else sleep would be re-entered at once with the key still held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         touch_reg <= '0;
      end else if (eval && (!sleep_active || touched)) begin
         touch_reg[k] <= touched;
      end
   end

   always_comb begin
      ev                = 3'h0;
      ev[`TBT_EV_TOUCH] = eval && !sleep_active && touched && !touch_reg[k];
      ev[`TBT_EV_REL]   = eval && !sleep_active && !touched && touch_reg[k];
      ev[`TBT_EV_LOCK]  = locked;
   end

   // register port: one write and one read in flight
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_go, wr_ok, rd_ok;
   logic [31:0] wr_val, rd_val;
   logic [3:0]  wi, ri;
   assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wi     = awaddr_q[5:2];
   assign ri     = s_axi_araddr[5:2];

   always_comb begin
      wr_ok = 1'b1;
      unique case (awaddr_q[11:6])
         `TBT_RG_MISC: wr_ok = wi <= `TBT_OFS_LOCK && wi != `TBT_OFS_KEYS;
         `TBT_RG_NTHR, `TBT_RG_LBR, `TBT_RG_PTHR, `TBT_RG_FTHR: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
      wr_val = merge(32'h0000_0000, wdata_q, wstrb_q);
   end

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr[11:6])
         `TBT_RG_MISC: begin
            unique case (ri)
               `TBT_OFS_CTRL:  rd_val = {28'h0, ctrl_reg};
               `TBT_OFS_ICFG:  rd_val = {29'h0, icfg_reg};
               `TBT_OFS_STAT:  rd_val = {29'h0, stat_reg};
               `TBT_OFS_MASK:  rd_val = {29'h0, mask_reg};
               `TBT_OFS_KEYS:  rd_val = {16'h0, touch_reg};
               `TBT_OFS_LOCK:  rd_val = {16'h0, lock_reg};
               `TBT_OFS_STATE: rd_val = {31'h0, sleep_active};
               default:        rd_ok  = 1'b0;
            endcase
         end
         `TBT_RG_NTHR: rd_val = {24'h0, nthr_reg[ri]};
         `TBT_RG_LBR:  rd_val = {24'h0, lbr_reg[ri]};
         `TBT_RG_PTHR: rd_val = {24'h0, pthr_reg[ri]};
         `TBT_RG_FTHR: rd_val = {24'h0, fthr_reg[ri]};
         `TBT_RG_BASE: rd_val = {16'h0, base_reg[ri]};
         `TBT_RG_RAW:  rd_val = {16'h0, raw_reg[ri]};
         `TBT_RG_CNT:  rd_val = {24'h0, cnt_reg[ri]};
         default:      rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TBT_RESP_OKAY;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_ok ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `TBT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_ok ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // host-written settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NKEY; i++) begin
            nthr_reg[i] <= `TBT_NTHR_RST;
            lbr_reg[i]  <= `TBT_LBR_RST;
            pthr_reg[i] <= `TBT_PTHR_RST;
            fthr_reg[i] <= `TBT_FTHR_RST;
         end
         lock_reg <= `TBT_LOCK_RST;
         icfg_reg <= `TBT_ICFG_RST;
         mask_reg <= 3'h0;
      end else if (wr_go && wr_ok) begin
         unique case (awaddr_q[11:6])
            `TBT_RG_NTHR: nthr_reg[wi] <= 8'(merge({24'h0, nthr_reg[wi]}, wdata_q, wstrb_q));
            `TBT_RG_LBR:  lbr_reg[wi]  <= 8'(merge({24'h0, lbr_reg[wi]}, wdata_q, wstrb_q));
            `TBT_RG_PTHR: pthr_reg[wi] <= 8'(merge({24'h0, pthr_reg[wi]}, wdata_q, wstrb_q));
            `TBT_RG_FTHR: fthr_reg[wi] <= 8'(merge({24'h0, fthr_reg[wi]}, wdata_q, wstrb_q));
            default: begin
               if (wi == `TBT_OFS_LOCK) lock_reg <= 16'(merge({16'h0, lock_reg}, wdata_q, wstrb_q));
               if (wi == `TBT_OFS_ICFG) icfg_reg <= 3'(merge({29'h0, icfg_reg}, wdata_q, wstrb_q));
               if (wi == `TBT_OFS_MASK) mask_reg <= 3'(merge({29'h0, mask_reg}, wdata_q, wstrb_q));
            end
         endcase
      end
   end

   logic w1c;
   assign w1c = wr_go && awaddr_q[11:6] == `TBT_RG_MISC && wi == `TBT_OFS_STAT;
   // a new event in the clearing cycle survives the clear
   assign stat_next = (stat_reg & ~(w1c ? wr_val[2:0] : 3'h0)) | (ev & icfg_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_reg    <= 3'h0;
         touch_irq_n <= 1'b1;
      end else begin
         stat_reg    <= stat_next;
         touch_irq_n <= ~|(stat_next & mask_reg);
      end
   end

   // pin functions and sleep; wake needs no host write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= '0;
         sleep_active <= 1'b0;
      end else begin
         if (wr_go && wr_ok && awaddr_q[11:6] == `TBT_RG_MISC && wi == `TBT_OFS_CTRL) begin
            ctrl_reg <= tbt_ctrl_t'(wr_val[3:0]);
         end
         if (sleep_active && eval && touched) begin
            sleep_active <= 1'b0;
         end else if (ctrl_reg.sleep_req && !sleep_active && !(|touch_reg)) begin
            sleep_active <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buzzer_sel        <= 1'b0;
         melody_power_ctrl <= 1'b0;
         addr_sel          <= 1'b0;
      end else begin
         buzzer_sel        <= ctrl_reg.key0_buzz;
         melody_power_ctrl <= ctrl_reg.key12_pow;
         addr_sel          <= ctrl_reg.key15_addr;
      end
   end

   always_ff @(posedge aclk) begin
      chk_key_q <= k;
      chk_raw_q <= scan_in.raw;
   end

   property p_base_track;
      @(posedge aclk) disable iff (!aresetn) eval && diff < {8'h00, pthr_reg[k]} |=> base_reg[chk_key_q] == chk_raw_q;
   endproperty
   a_base_track: assert property (p_base_track) else $error("baseline did not follow raw");
   property p_cnt_inc;
      @(posedge aclk) disable iff (!aresetn) eval && over && !lbr_hit |=> cnt_reg[chk_key_q] == $past(cnt_inc);
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("low count did not step");
   property p_lbr_force;
      @(posedge aclk) disable iff (!aresetn) eval && lbr_hit |=> base_reg[chk_key_q] == chk_raw_q;
   endproperty
   a_lbr_force: assert property (p_lbr_force) else $error("baseline not forced at limit");
   property p_cnt_clear;
      @(posedge aclk) disable iff (!aresetn) eval && !over |=> cnt_reg[chk_key_q] == 8'h00;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("low count not cleared");
   property p_lock_skip;
      @(posedge aclk) disable iff (!aresetn) locked |=> base_reg[chk_key_q] == $past(cur_base) && $stable(touch_reg);
   endproperty
   a_lock_skip: assert property (p_lock_skip) else $error("locked scan changed state");
   property p_irq_level;
      @(posedge aclk) disable iff (!aresetn) $stable(mask_reg) |-> touch_irq_n == !(|(stat_reg & mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
   property p_touch_set;
      @(posedge aclk) disable iff (!aresetn) ev[`TBT_EV_TOUCH] && icfg_reg[`TBT_EV_TOUCH] |=> stat_reg[`TBT_EV_TOUCH];
   endproperty
   a_touch_set: assert property (p_touch_set) else $error("touch event lost");
   property p_pin_skip;
      @(posedge aclk) disable iff (!aresetn) scan_valid && pin_used |=> base_reg[chk_key_q] == $past(cur_base);
   endproperty
   a_pin_skip: assert property (p_pin_skip) else $error("shared pin was tracked");
   property p_wake;
      @(posedge aclk) disable iff (!aresetn) sleep_active && eval && touched |=> !sleep_active;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on touch");
   property p_reset;
      @(posedge aclk) !aresetn |=> touch_irq_n && base_reg[0] == 16'h0000 && cnt_reg[0] == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_bresp;
      @(posedge aclk) disable iff (!aresetn) wr_go |=> s_axi_bvalid ##0 s_axi_bvalid [*1];
   endproperty
   a_bresp: assert property (p_bresp) else $error("write not answered");
endmodule

/* hw/tbt_consts.svh */
// How it works
// - Each scan copies the raw count into the baseline when the baseline gap is below the key's positive noise threshold.
// - Each key keeps a low-baseline counter that steps up when |raw - baseline| is above the negative noise threshold.
// - When that counter passes the key's low baseline reset limit, the baseline is forced to the raw count.
// - The counter returns to zero on any scan where |raw - baseline| is at or below the negative noise threshold.
// - A scan whose signal is above the lock threshold is thrown away and yields no touch decision.
// - A touch trigger event drives the active-low interrupt, and the host chooses which events count.
// - Sixteen channels each keep their own raw count, baseline, thresholds and status.
// - Channel 0 may be a buzzer, channel 12 a melody power control and channel 15 an address select.
// - The host reaches the device through a slave register port and must not overdrive its rate.
// - Sleep ends by itself when a scan senses a touch, without any host action.
// - Each key has a writable negative noise threshold that resets to 28h.
// - Each key has a writable low baseline reset limit that resets to 1Eh.
`ifndef TBT_CONSTS_SVH
`define TBT_CONSTS_SVH
`define TBT_RAW_W        16
`define TBT_THR_W        8
`define TBT_NTHR_RST     8'h28
`define TBT_LBR_RST      8'h1E
`define TBT_PTHR_RST     8'h28
`define TBT_FTHR_RST     8'h50
`define TBT_LOCK_RST     16'h03E8
`define TBT_ICFG_RST     3'h1
`define TBT_CNT_MAX      8'hFF
`define TBT_OFS_CTRL     4'h0
`define TBT_OFS_ICFG     4'h1
`define TBT_OFS_STAT     4'h2
`define TBT_OFS_MASK     4'h3
`define TBT_OFS_KEYS     4'h4
`define TBT_OFS_LOCK     4'h5
`define TBT_OFS_STATE    4'h6
`define TBT_RG_MISC      6'h00
`define TBT_RG_NTHR      6'h04
`define TBT_RG_LBR       6'h05
`define TBT_RG_PTHR      6'h06
`define TBT_RG_FTHR      6'h07
`define TBT_RG_BASE      6'h08
`define TBT_RG_RAW       6'h09
`define TBT_RG_CNT       6'h0A
`define TBT_EV_TOUCH     0
`define TBT_EV_REL       1
`define TBT_EV_LOCK      2
`define TBT_RESP_OKAY    2'h0
`define TBT_RESP_SLVERR  2'h2
`endif

/* hw/tbt_pkg.sv */
package tbt_pkg;
   typedef struct packed {
      logic [3:0]  key;
      logic [15:0] raw;
   } tbt_scan_t;
   typedef struct packed {
      logic sleep_req;
      logic key15_addr;
      logic key12_pow;
      logic key0_buzz;
   } tbt_ctrl_t;
endpackage

/* bench/tbt_host_model.sv */
`timescale 1ns/100ps
module tbt_host_model (
   input  wire logic        aclk,
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // one access at a time, so the host never outruns the register port
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
endmodule

/* bench/tbt_touch_baseline_tracker_tb_top.sv */
`timescale 1ns/100ps
module tbt_touch_baseline_tracker_tb_top;
   import tbt_pkg::*;
   typedef struct packed {
      logic [3:0]  k;
      logic [15:0] raw;
      logic [15:0] base;
      logic [7:0]  cnt;
   } tbt_row_t;
   logic              aclk;
   logic              aresetn;
   logic              scan_valid;
   tbt_scan_t         scan_in;
   logic [11:0]       awaddr, araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [31:0]       wdata, rdata, d;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   logic              touch_irq_n, buzzer_sel, melody_power_ctrl, addr_sel, sleep_active;
   int                fail_count, tests_run;
   tbt_row_t          rows [9];

   tbt_touch_baseline_tracker tbt_touch_baseline_tracker_inst (
      .aclk(aclk), .aresetn(aresetn), .scan_valid(scan_valid), .scan_in(scan_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .touch_irq_n(touch_irq_n), .buzzer_sel(buzzer_sel), .melody_power_ctrl(melody_power_ctrl),
      .addr_sel(addr_sel), .sleep_active(sleep_active));
   tbt_host_model tbt_host_model_inst (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      tbt_host_model_inst.rd(a, d, r);
      chk(n, e, d);
      chk({n, " resp"}, 32'h0, r);
   endtask
   task automatic wrc(input logic [11:0] a, input logic [31:0] dv);
      tbt_host_model_inst.wr(a, dv, r);
      chk("write resp", 32'h0, r);
   endtask
   task automatic scan(input logic [3:0] k, input logic [15:0] raw);
      @(posedge aclk);
      scan_valid <= 1'b1;
      scan_in <= '{key: k, raw: raw};
      @(posedge aclk);
      scan_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      summarize();
   end

   initial begin
      aresetn = 1'b0;
      scan_valid = 1'b0;
      scan_in = '0;
      fail_count = 0;
      tests_run = 0;
      // lbr of key 1 lowered to 2 so the forced reset shows after three far scans
      rows = '{'{4'h1, 16'h0010, 16'h0010, 8'h00}, '{4'h1, 16'h0040, 16'h0010, 8'h01},
               '{4'h1, 16'h0040, 16'h0010, 8'h02}, '{4'h1, 16'h0040, 16'h0040, 8'h00},
               '{4'h1, 16'h0069, 16'h0040, 8'h01}, '{4'h1, 16'h0429, 16'h0040, 8'h01},
               '{4'h1, 16'h0068, 16'h0040, 8'h00}, '{4'h1, 16'h0067, 16'h0067, 8'h00},
               '{4'hF, 16'h0020, 16'h0020, 8'h00}};
      do_reset();
      chk("irq after reset", 32'h1, touch_irq_n);
      rdc("neg thr", 12'h10C, 32'h28);
      rdc("lbr", 12'h14C, 32'h1E);
      rdc("lock thr", 12'h014, 32'h3E8);
      rdc("icfg", 12'h004, 32'h1);
      rdc("base k3", 12'h20C, 32'h0);
      wrc(12'h144, 32'h2);
      foreach (rows[i]) begin
         scan(rows[i].k, rows[i].raw);
         rdc("base", 12'h200 + 12'(rows[i].k) * 12'h004, 32'(rows[i].base));
         rdc("count", 12'h280 + 12'(rows[i].k) * 12'h004, 32'(rows[i].cnt));
      end
      rdc("no touch from locked scan", 12'h010, 32'h0);
      tbt_host_model_inst.rd(12'h7FC, d, r);
      chk("unmapped resp", 32'h2, r);
      chk("unmapped data", 32'h0, d);
      tbt_host_model_inst.wr(12'h010, 32'hFFFF, r);
      chk("read-only write resp", 32'h2, r);
      // interrupt: raised while masked, unmasked, cleared
      scan(4'h2, 16'h0010);
      scan(4'h2, 16'h0060);
      rdc("key status", 12'h010, 32'h4);
      rdc("status", 12'h008, 32'h1);
      chk("irq masked", 32'h1, touch_irq_n);
      wrc(12'h00C, 32'h7);
      repeat (3) @(posedge aclk);
      chk("irq unmasked", 32'h0, touch_irq_n);
      wrc(12'h008, 32'h1);
      repeat (3) @(posedge aclk);
      chk("irq cleared", 32'h1, touch_irq_n);
      // lock event only
      wrc(12'h004, 32'h4);
      scan(4'h4, 16'h03E9);
      chk("irq on lock", 32'h0, touch_irq_n);
      rdc("lock status", 12'h008, 32'h4);
      wrc(12'h008, 32'h4);
      wrc(12'h004, 32'h1);
      // shared pins: key 0 as buzzer ignores its scans
      wrc(12'h000, 32'h7);
      repeat (2) @(posedge aclk);
      chk("pin selects", 32'h7, {addr_sel, melody_power_ctrl, buzzer_sel});
      scan(4'h0, 16'h0020);
      rdc("base k0 buzzer", 12'h200, 32'h0);
      wrc(12'h000, 32'h0);
      scan(4'h0, 16'h0020);
      rdc("base k0 key", 12'h200, 32'h20);
      // release event only, then sleep and wake by touch
      wrc(12'h004, 32'h2);
      scan(4'h2, 16'h0010);
      chk("irq on release", 32'h0, touch_irq_n);
      rdc("release status", 12'h008, 32'h2);
      wrc(12'h008, 32'h2);
      wrc(12'h004, 32'h1);
      wrc(12'h000, 32'h8);
      repeat (3) @(posedge aclk);
      chk("asleep", 32'h1, sleep_active);
      rdc("state", 12'h018, 32'h1);
      scan(4'h5, 16'h0050);
      chk("woken", 32'h0, sleep_active);
      rdc("wake key kept", 12'h010, 32'h20);
      // reset in mid-run while irq is low
      scan(4'h3, 16'h0060);
      chk("irq before reset", 32'h0, touch_irq_n);
      do_reset();
      chk("irq reset", 32'h1, touch_irq_n);
      chk("sleep reset", 32'h0, sleep_active);
      rdc("base k3 reset", 12'h20C, 32'h0);
      rdc("count k3 reset", 12'h28C, 32'h0);
      rdc("lbr k1 reset", 12'h144, 32'h1E);
      summarize();
   end
endmodule
